//--- common/gmi_pkg.sv
// Purpose: shared constants and types for the gateway modem init block
// Assumes: one 40 MHz clock, synchronous active-low reset
// Notes: presence timer counts ticks of a local time base
package gmi_pkg;
  localparam int CLK_MHZ = 40;
  localparam int PRESENCE_MS = 2;
  // presence limit in time-base ticks (1 tick per microsecond)
  localparam int PRESENCE_TICKS = PRESENCE_MS * 1000;
  localparam int TICK_CYCLES = CLK_MHZ;
  localparam int UPSTREAM_CHANNEL_ID_W = 8;
  localparam int CHAN_W = 8;
  localparam int VAL_W = 8;
  localparam logic [UPSTREAM_CHANNEL_ID_W-1:0] UPSTREAM_CHANNEL_ID_RESET = 8'hff;

  // initialization machine states
  typedef enum logic [3:0] {
    GMI_IDLE = 4'h0,
    GMI_SCAN = 4'h1,
    GMI_PRES = 4'h3,
    GMI_MDD = 4'h2,
    GMI_AMBIG = 4'h6,
    GMI_WAITV = 4'h7,
    GMI_SGSCAN = 4'h5,
    GMI_UPACQ = 4'h4,
    GMI_CONN = 4'hc,
    GMI_REG = 4'hd,
    GMI_TWOWAY = 4'hf,
    GMI_ONEWAY = 4'he,
    GMI_DISABLED = 4'ha,
    GMI_LEGACY = 4'hb
  } gmi_init_state_t;

  typedef enum logic [1:0] {
    GMI_T_IDLE = 2'h0,
    GMI_T_ADV = 2'h1,
    GMI_T_FILT = 2'h3
  } gmi_tun_state_t;
endpackage

//--- common/gmi_tun_if.sv
// Purpose: signals between the init machine and the tunnel machine
// Assumes: single clock domain
// Notes: these signals never leave the modem
`timescale 1ns/1ps
interface gmi_tun_if;
  logic advanced;
  logic valid_chan;
  logic invalid_chan;
  logic hunt;
  modport tun (output advanced, output valid_chan, output invalid_chan,
    output hunt);
  modport init (input advanced, input valid_chan, input invalid_chan,
    input hunt);
endinterface

//--- design/gmi_top.sv
// Purpose: gateway modem init machine with tunnel machine beside it
// Assumes: link events arrive as one-cycle pulses from the modem core
// Notes: controller messages are one-cycle pulses with data in flops
//
// Overview of operation
// - no scanning until the controller sets advanced mode
// - keep scanning while a locked channel lacks gateway tunnels
// - no descriptors on a locked channel: retune to next channel
// - with descriptors, look for a domain descriptor of matching source
// - no matching domain descriptor: take the legacy init path
// - matching domain descriptor: resolve the downstream service group
// - forward descriptor after resolution; continue only on valid reply
// - invalid reply: scan other channels of the service group
// - drop foreign-source descriptors, forward matching ones
// - none accepted in the domain: resume general scan
// - upstream, ranging, connectivity or registration failure: one-way
// - presence validation runs a timer; expiry resumes scanning
// - descriptor found stops timer and signals channel found
// - continue-scan and channel-found stay internal
// - disable/enable transmitter; disable silences every upstream
// - two-way reached: report success with lowest transmit channel id
// - report scan done, one-way, cannot forward, channel-change depart
// - tunnel machine takes start, filter and hunt commands
// - tunnel machine reports descriptor info and reinit events
// - two concurrent machines; tunnel feeds validity to init
// - controller may supply a frequency list to speed acquisition
// - configuration file frequency and channel list still apply
// - disable command stops transmit at once; from upstream, connectivity, registration or two-way it enters disabled state
// - one-way mode stays tuned and keeps tunnel traffic
// - collect domain descriptor only with matching source address
`timescale 1ns/1ps
module gmi_top #(
  parameter int PRESENCE_LIMIT = gmi_pkg::PRESENCE_TICKS,
  parameter int TICK_DIV = gmi_pkg::TICK_CYCLES,
  parameter int MAC_W = 48,
  parameter int NCH = 8
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic START_ADV,
  input wire logic FILTER_CMD,
  input wire logic [MAC_W-1:0] FILTER_MAC,
  input wire logic VALID_CMD,
  input wire logic HUNT_CMD,
  input wire logic TX_DISABLE_CMD,
  input wire logic TX_ENABLE_CMD,
  input wire logic FREQ_LIST_VALID,
  input wire logic [gmi_pkg::CHAN_W-1:0] FREQ_LIST_CHAN,
  input wire logic CFG_CHAN_VALID,
  input wire logic [gmi_pkg::CHAN_W-1:0] CFG_CHAN,
  input wire logic LOCKED,
  input wire logic TUNNELS_OK,
  input wire logic DCD_SEEN,
  input wire logic [MAC_W-1:0] DCD_SRC,
  input wire logic MDD_SEEN,
  input wire logic [MAC_W-1:0] MDD_SRC,
  input wire logic SG_DONE,
  input wire logic [NCH-1:0] SG_CHANS,
  input wire logic UP_OK,
  input wire logic UP_FAIL,
  input wire logic CONN_OK,
  input wire logic CONN_FAIL,
  input wire logic REG_OK,
  input wire logic REG_FAIL,
  input wire logic MULTI_TX,
  input wire logic [NCH-1:0] TX_SET,
  input wire logic [gmi_pkg::UPSTREAM_CHANNEL_ID_W-1:0] SINGLE_UPSTREAM_CHANNEL_ID,
  input wire logic NO_FWD,
  input wire logic [gmi_pkg::VAL_W-1:0] NETWORK_ACCESS_CONTROL_VAL,
  input wire logic [gmi_pkg::VAL_W-1:0] MAX_CPE_VAL,
  input wire logic CC_DEPART,
  input wire logic [1:0] CC_INIT_TYPE,
  input wire logic MAC_REINIT,
  output logic RETUNE,
  output logic [gmi_pkg::CHAN_W-1:0] TUNE_CHAN,
  output logic FWD_DCD,
  output logic MDD_COLLECT,
  output logic LEGACY_INIT,
  output logic UP_TX_EN,
  output logic SCAN_DONE,
  output logic TWOWAY_OK,
  output logic [gmi_pkg::UPSTREAM_CHANNEL_ID_W-1:0] UPSTREAM_CHANNEL_ID,
  output logic ONEWAY,
  output logic CANT_FWD,
  output logic [gmi_pkg::VAL_W-1:0] NETWORK_ACCESS_CONTROL_OUT,
  output logic [gmi_pkg::VAL_W-1:0] MAX_CPE_OUT,
  output logic CC_DEPART_OUT,
  output logic [1:0] CC_TYPE_OUT,
  output logic DCD_INFO,
  output logic REINIT_OUT,
  output logic [MAC_W-1:0] FILTER_MAC_OUT,
  output logic [gmi_pkg::UPSTREAM_CHANNEL_ID_W-1:0] TX_DISABLED
);
  gmi_tun_if tif ();

  gmi_tunnel #(.MAC_W(MAC_W)) u_tun (
    .clk(CLK),
    .resetn(RESETN),
    .cmd_start_adv(START_ADV),
    .cmd_filter(FILTER_CMD),
    .filter_mac(FILTER_MAC),
    .cmd_hunt(HUNT_CMD),
    .cmd_valid(VALID_CMD),
    .dcd_in(DCD_SEEN),
    .mac_reinit(MAC_REINIT),
    .dcd_info(DCD_INFO),
    .reinit_evt(REINIT_OUT),
    .filter_mac_q(FILTER_MAC_OUT),
    .tif(tif)
  );

  // lowest set index of the transmit channel set
  function automatic logic [gmi_pkg::UPSTREAM_CHANNEL_ID_W-1:0] lowest(
      input logic [NCH-1:0] v);
    logic [gmi_pkg::UPSTREAM_CHANNEL_ID_W-1:0] r;
    r = gmi_pkg::UPSTREAM_CHANNEL_ID_RESET;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (v[i]) r = gmi_pkg::UPSTREAM_CHANNEL_ID_W'(i);
    end
    return r;
  endfunction

  gmi_pkg::gmi_init_state_t st_q, st_d;
  logic [MAC_W-1:0] dom_q, dom_d;
  logic [NCH-1:0] sg_q, sg_d;
  logic [gmi_pkg::CHAN_W-1:0] ch_q, ch_d;
  logic [31:0] tmr_q, tmr_d;
  logic [31:0] div_q, div_d;
  logic tx_q, tx_d, txoff_q, txoff_d;
  logic chan_found, cont_scan;
  logic retune_d, fwd_d, coll_d, leg_d, done_d, ok_d, ow_d;
  logic [gmi_pkg::UPSTREAM_CHANNEL_ID_W-1:0] upstream_channel_id_d;
  logic mdd_match;

  assign mdd_match = MDD_SEEN && (MDD_SRC == dom_q);
  // internal only, never on a port
  assign chan_found = (st_q == gmi_pkg::GMI_PRES) && DCD_SEEN;
  assign cont_scan = (st_q == gmi_pkg::GMI_PRES) && !DCD_SEEN &&
                     (tmr_q >= 32'(PRESENCE_LIMIT));

  always_comb begin
    st_d = st_q;
    dom_d = dom_q;
    sg_d = sg_q;
    ch_d = ch_q;
    tmr_d = tmr_q;
    div_d = div_q;
    tx_d = tx_q;
    txoff_d = txoff_q;
    retune_d = 1'b0;
    fwd_d = 1'b0;
    coll_d = 1'b0;
    leg_d = 1'b0;
    done_d = 1'b0;
    ok_d = 1'b0;
    ow_d = 1'b0;
    upstream_channel_id_d = UPSTREAM_CHANNEL_ID;
    if (TX_ENABLE_CMD) txoff_d = 1'b0;
    unique case (st_q)
      gmi_pkg::GMI_IDLE: begin
        if (tif.advanced) begin
          st_d = gmi_pkg::GMI_SCAN;
          retune_d = 1'b1;
        end
      end
      gmi_pkg::GMI_SCAN: begin
        if (FREQ_LIST_VALID) ch_d = FREQ_LIST_CHAN;
        if (LOCKED) begin
          if (!TUNNELS_OK) begin
            ch_d = ch_q + 1'b1;
            retune_d = 1'b1;
          end else begin
            st_d = gmi_pkg::GMI_PRES;
            tmr_d = '0;
            div_d = '0;
          end
        end
      end
      gmi_pkg::GMI_PRES: begin
        if (div_q == 32'(TICK_DIV - 1)) begin
          div_d = '0;
          tmr_d = tmr_q + 1'b1;
        end else begin
          div_d = div_q + 1'b1;
        end
        if (chan_found) begin
          dom_d = DCD_SRC;
          st_d = gmi_pkg::GMI_MDD;
          done_d = 1'b1;
        end else if (cont_scan) begin
          st_d = gmi_pkg::GMI_SCAN;
          ch_d = ch_q + 1'b1;
          retune_d = 1'b1;
        end
      end
      gmi_pkg::GMI_MDD: begin
        coll_d = mdd_match;
        if (mdd_match) st_d = gmi_pkg::GMI_AMBIG;
        else if (DCD_SEEN) begin
          st_d = gmi_pkg::GMI_LEGACY;
          leg_d = 1'b1;
        end
      end
      gmi_pkg::GMI_LEGACY: st_d = gmi_pkg::GMI_UPACQ;
      gmi_pkg::GMI_AMBIG: begin
        if (SG_DONE) begin
          sg_d = SG_CHANS;
          st_d = gmi_pkg::GMI_WAITV;
          fwd_d = 1'b1;
        end
      end
      gmi_pkg::GMI_WAITV: begin
        if (tif.valid_chan) st_d = gmi_pkg::GMI_UPACQ;
        else if (tif.invalid_chan) begin
          if (sg_q == '0) begin
            st_d = gmi_pkg::GMI_SCAN;
            ch_d = ch_q + 1'b1;
          end else begin
            st_d = gmi_pkg::GMI_SGSCAN;
            ch_d = lowest(sg_q);
            sg_d = sg_q & ~(NCH'(1) << lowest(sg_q));
          end
          retune_d = 1'b1;
        end
      end
      gmi_pkg::GMI_SGSCAN: begin
        if (DCD_SEEN && DCD_SRC == dom_q) begin
          fwd_d = 1'b1;
          st_d = gmi_pkg::GMI_WAITV;
        end
      end
      gmi_pkg::GMI_UPACQ: begin
        tx_d = 1'b1;
        if (UP_FAIL) st_d = gmi_pkg::GMI_ONEWAY;
        else if (UP_OK) st_d = gmi_pkg::GMI_CONN;
      end
      gmi_pkg::GMI_CONN: begin
        if (CONN_FAIL) st_d = gmi_pkg::GMI_ONEWAY;
        else if (CONN_OK) st_d = gmi_pkg::GMI_REG;
      end
      gmi_pkg::GMI_REG: begin
        if (CFG_CHAN_VALID) ch_d = CFG_CHAN;
        if (REG_FAIL) st_d = gmi_pkg::GMI_ONEWAY;
        else if (REG_OK) begin
          st_d = gmi_pkg::GMI_TWOWAY;
          ok_d = 1'b1;
          upstream_channel_id_d = MULTI_TX ? lowest(TX_SET) : SINGLE_UPSTREAM_CHANNEL_ID;
        end
      end
      gmi_pkg::GMI_TWOWAY: begin
        if (CFG_CHAN_VALID) begin
          ch_d = CFG_CHAN;
          retune_d = 1'b1;
        end
      end
      gmi_pkg::GMI_ONEWAY: tx_d = 1'b0;
      gmi_pkg::GMI_DISABLED: begin
        if (TX_ENABLE_CMD) st_d = gmi_pkg::GMI_UPACQ;
      end
      default: st_d = gmi_pkg::GMI_IDLE;
    endcase
    if (TX_DISABLE_CMD) begin
      txoff_d = 1'b1;
      tx_d = 1'b0;
      if (st_q inside {gmi_pkg::GMI_UPACQ, gmi_pkg::GMI_CONN,
          gmi_pkg::GMI_REG, gmi_pkg::GMI_TWOWAY})
        st_d = gmi_pkg::GMI_DISABLED;
    end
    if (tif.hunt && st_q != gmi_pkg::GMI_WAITV &&
        st_q != gmi_pkg::GMI_IDLE) begin
      st_d = gmi_pkg::GMI_SCAN;
      tx_d = 1'b0;
      retune_d = 1'b1;
    end
    // after the overrides, so a disable or hunt never reports one-way
    if (st_d == gmi_pkg::GMI_ONEWAY && st_q != gmi_pkg::GMI_ONEWAY) begin
      ow_d = 1'b1;
      tx_d = 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      st_q <= gmi_pkg::GMI_IDLE;
      dom_q <= '0;
      sg_q <= '0;
      ch_q <= '0;
      tmr_q <= '0;
      div_q <= '0;
      tx_q <= 1'b0;
      txoff_q <= 1'b0;
      RETUNE <= 1'b0;
      FWD_DCD <= 1'b0;
      MDD_COLLECT <= 1'b0;
      LEGACY_INIT <= 1'b0;
      SCAN_DONE <= 1'b0;
      TWOWAY_OK <= 1'b0;
      UPSTREAM_CHANNEL_ID <= gmi_pkg::UPSTREAM_CHANNEL_ID_RESET;
      ONEWAY <= 1'b0;
      CANT_FWD <= 1'b0;
      NETWORK_ACCESS_CONTROL_OUT <= '0;
      MAX_CPE_OUT <= '0;
      CC_DEPART_OUT <= 1'b0;
      CC_TYPE_OUT <= '0;
    end else begin
      st_q <= st_d;
      dom_q <= dom_d;
      sg_q <= sg_d;
      ch_q <= ch_d;
      tmr_q <= tmr_d;
      div_q <= div_d;
      tx_q <= tx_d;
      txoff_q <= txoff_d;
      RETUNE <= retune_d;
      FWD_DCD <= fwd_d;
      MDD_COLLECT <= coll_d;
      LEGACY_INIT <= leg_d;
      SCAN_DONE <= done_d;
      TWOWAY_OK <= ok_d;
      UPSTREAM_CHANNEL_ID <= upstream_channel_id_d;
      ONEWAY <= ow_d;
      CANT_FWD <= NO_FWD;
      if (NO_FWD) begin
        NETWORK_ACCESS_CONTROL_OUT <= NETWORK_ACCESS_CONTROL_VAL;
        MAX_CPE_OUT <= MAX_CPE_VAL;
      end
      CC_DEPART_OUT <= CC_DEPART;
      if (CC_DEPART) CC_TYPE_OUT <= CC_INIT_TYPE;
    end
  end

  assign TUNE_CHAN = ch_q;
  // disable silences the transmitter combinationally, at once
  assign UP_TX_EN = tx_q && !txoff_q && !TX_DISABLE_CMD;
  assign TX_DISABLED = {{(gmi_pkg::UPSTREAM_CHANNEL_ID_W-1){1'b0}}, txoff_q};
endmodule // gmi_top

//--- design/gmi_tunnel.sv
// Purpose: tunnel operation machine
// Assumes: controller commands are one-cycle pulses
// Notes: feeds validity into the init machine
`timescale 1ns/1ps
module gmi_tunnel #(
  parameter int MAC_W = 48
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic cmd_start_adv,
  input wire logic cmd_filter,
  input wire logic [MAC_W-1:0] filter_mac,
  input wire logic cmd_hunt,
  input wire logic cmd_valid,
  input wire logic dcd_in,
  input wire logic mac_reinit,
  output logic dcd_info,
  output logic reinit_evt,
  output logic [MAC_W-1:0] filter_mac_q,
  gmi_tun_if.tun tif
);
  gmi_pkg::gmi_tun_state_t state_q, state_d;
  logic [MAC_W-1:0] mac_d;
  logic dcd_d, reinit_d;

  always_comb begin
    state_d = state_q;
    mac_d = filter_mac_q;
    dcd_d = 1'b0;
    reinit_d = mac_reinit;
    unique case (state_q)
      gmi_pkg::GMI_T_IDLE: begin
        if (cmd_start_adv) state_d = gmi_pkg::GMI_T_ADV;
      end
      gmi_pkg::GMI_T_ADV, gmi_pkg::GMI_T_FILT: begin
        dcd_d = dcd_in;
        if (cmd_filter) begin
          mac_d = filter_mac;
          state_d = gmi_pkg::GMI_T_FILT;
        end
      end
      default: state_d = gmi_pkg::GMI_T_IDLE;
    endcase
    if (mac_reinit) state_d = gmi_pkg::GMI_T_IDLE;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q <= gmi_pkg::GMI_T_IDLE;
      filter_mac_q <= '0;
      dcd_info <= 1'b0;
      reinit_evt <= 1'b0;
    end else begin
      state_q <= state_d;
      filter_mac_q <= mac_d;
      dcd_info <= dcd_d;
      reinit_evt <= reinit_d;
    end
  end

  // validity inputs for the init machine
  assign tif.advanced = (state_q != gmi_pkg::GMI_T_IDLE);
  assign tif.valid_chan = cmd_valid && (state_q != gmi_pkg::GMI_T_IDLE);
  assign tif.invalid_chan = cmd_hunt && (state_q != gmi_pkg::GMI_T_IDLE);
  assign tif.hunt = tif.invalid_chan;
endmodule // gmi_tunnel

//--- verif/gmi_ctrl_model.sv
// Purpose: tunnel client controller model
// Assumes: commands are one-cycle pulses
// Notes: replies valid or hunt after a chosen delay
`timescale 1ns/1ps
module gmi_ctrl_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic go,
  input wire logic fwd,
  input wire logic accept,
  input wire logic [3:0] dly,
  output logic start_adv = 1'b0,
  output logic valid_cmd = 1'b0,
  output logic hunt_cmd = 1'b0
);
  int cnt = 0;
  always @(posedge clk) begin
    start_adv <= resetn & go;
    valid_cmd <= 1'b0;
    hunt_cmd <= 1'b0;
    if (!resetn || fwd) begin
      cnt <= fwd ? int'(dly) + 1 : 0;
    end else if (cnt == 1) begin
      valid_cmd <= accept;
      hunt_cmd <= !accept;
      cnt <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule // gmi_ctrl_model

//--- verif/gmi_top_props.sv
// Purpose: port-level checks for the gateway modem init block
// Assumes: one clock, synchronous active-low reset
// Notes: bound into every gmi_top instance
`timescale 1ns/1ps
module gmi_top_props #(
  parameter int MAC_W = 48,
  parameter int NCH = 8
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic START_ADV,
  input wire logic TX_DISABLE_CMD,
  input wire logic TX_ENABLE_CMD,
  input wire logic DCD_SEEN,
  input wire logic [MAC_W-1:0] DCD_SRC,
  input wire logic MDD_SEEN,
  input wire logic [MAC_W-1:0] MDD_SRC,
  input wire logic SG_DONE,
  input wire logic UP_FAIL,
  input wire logic CONN_FAIL,
  input wire logic REG_FAIL,
  input wire logic MULTI_TX,
  input wire logic [NCH-1:0] TX_SET,
  input wire logic MAC_REINIT,
  input wire logic RETUNE,
  input wire logic SCAN_DONE,
  input wire logic FWD_DCD,
  input wire logic MDD_COLLECT,
  input wire logic UP_TX_EN,
  input wire logic TWOWAY_OK,
  input wire logic [gmi_pkg::UPSTREAM_CHANNEL_ID_W-1:0] UPSTREAM_CHANNEL_ID,
  input wire logic ONEWAY,
  input wire logic REINIT_OUT
);
  logic adv_q;
  logic adv_d;
  logic [gmi_pkg::UPSTREAM_CHANNEL_ID_W-1:0] low_id;
  logic [MAC_W-1:0] src_q;
  logic [MAC_W-1:0] dom_q;
  logic [NCH-1:0] txs_q;
  always_comb adv_d = adv_q | START_ADV;
  always_ff @(posedge CLK) adv_q <= RESETN & adv_d;
  // domain address: source of the descriptor that ended the scan
  always_ff @(posedge CLK) begin
    if (DCD_SEEN) begin
      src_q <= DCD_SRC;
    end
    if (SCAN_DONE) begin
      dom_q <= src_q;
    end
    txs_q <= TX_SET;
  end
  // lowest set bit of the set seen with the registration result
  always_comb begin
    low_id = gmi_pkg::UPSTREAM_CHANNEL_ID_RESET;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (txs_q[i]) begin
        low_id = i[gmi_pkg::UPSTREAM_CHANNEL_ID_W-1:0];
      end
    end
  end
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);
  property p_no_scan_early;
    !adv_q |-> !RETUNE && !SCAN_DONE;
  endproperty
  a_no_scan_early: assert property (p_no_scan_early)
    else $error("scan activity before advanced mode");
  property p_tx_now;
    TX_DISABLE_CMD |-> !UP_TX_EN;
  endproperty
  a_tx_now: assert property (p_tx_now)
    else $error("transmit still enabled on disable");
  property p_tx_hold;
    TX_DISABLE_CMD && !TX_ENABLE_CMD |=> !UP_TX_EN;
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("transmit back on after disable");
  property p_scan_cause;
    SCAN_DONE |-> $past(DCD_SEEN);
  endproperty
  a_scan_cause: assert property (p_scan_cause)
    else $error("scan done without descriptor");
  property p_mdd_match;
    MDD_COLLECT |-> $past(MDD_SEEN) && $past(MDD_SRC) == dom_q;
  endproperty
  a_mdd_match: assert property (p_mdd_match)
    else $error("domain descriptor collected with foreign source");
  property p_fwd_cause;
    FWD_DCD |-> $past(SG_DONE) || $past(DCD_SEEN);
  endproperty
  a_fwd_cause: assert property (p_fwd_cause)
    else $error("descriptor forwarded without cause");
  property p_oneway_cause;
    $rose(ONEWAY) |-> $past(UP_FAIL) || $past(CONN_FAIL) || $past(REG_FAIL);
  endproperty
  a_oneway_cause: assert property (p_oneway_cause)
    else $error("one-way entered without failure");
  property p_upstream_channel_id_low;
    TWOWAY_OK && $past(MULTI_TX) |-> UPSTREAM_CHANNEL_ID == low_id;
  endproperty
  a_upstream_channel_id_low: assert property (p_upstream_channel_id_low)
    else $error("reported channel id not lowest");
  property p_reinit;
    MAC_REINIT |=> REINIT_OUT;
  endproperty
  a_reinit: assert property (p_reinit)
    else $error("reinit event not reported");
  c_twoway: cover property (TWOWAY_OK);
  c_oneway: cover property (ONEWAY);
  c_mdd: cover property (MDD_COLLECT);
endmodule // gmi_top_props

bind gmi_top gmi_top_props #(.MAC_W(MAC_W), .NCH(NCH)) u_props (.*);

//--- verif/tb_gateway_modem_init_fsm.sv
// Purpose: self-checking bench for the gateway modem init block
// Assumes: 40 MHz clock, reset held 8 cycles
// Notes: short presence limit keeps the run brief
`timescale 1ns/1ps
module tb_gateway_modem_init_fsm;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [17:0] ev = '0;
  logic [7:0] fch = 8'h00;
  logic [7:0] cch = 8'h00;
  logic lk = 1'b0;
  logic tok = 1'b0;
  logic acc = 1'b0;
  logic mtx = 1'b0;
  logic [3:0] dly = 4'h0;
  logic [47:0] dsrc = 48'h0;
  logic [47:0] msrc = 48'h0;
  logic [47:0] fmac = 48'h0;
  logic [7:0] sgc = 8'h01;
  logic [7:0] txs = 8'h01;
  logic [7:0] network_access_control = 8'h00;
  logic [7:0] mcpe = 8'h00;
  logic [1:0] cct = 2'h0;
  logic sadv, vld, hnt, up_en;
  logic [7:0] tch, upstream_channel_id, nout, mout, txdis;
  logic [1:0] ctyp;
  logic [47:0] fout;
  logic [10:0] pv;
  int n_fail = 0;
  int cmp_count = 0;
  int c;
  always #12.5 clk = ~clk;
  gmi_top #(.PRESENCE_LIMIT(4), .TICK_DIV(2)) dut (
    .CLK(clk), .RESETN(resetn), .START_ADV(sadv), .FILTER_CMD(ev[12]),
    .FILTER_MAC(fmac), .VALID_CMD(vld), .HUNT_CMD(hnt),
    .TX_DISABLE_CMD(ev[13]), .TX_ENABLE_CMD(ev[14]),
    .FREQ_LIST_VALID(ev[16]), .FREQ_LIST_CHAN(fch),
    .CFG_CHAN_VALID(ev[17]), .CFG_CHAN(cch), .LOCKED(lk),
    .TUNNELS_OK(tok), .DCD_SEEN(ev[0]), .DCD_SRC(dsrc),
    .MDD_SEEN(ev[1]), .MDD_SRC(msrc), .SG_DONE(ev[2]), .SG_CHANS(sgc),
    .UP_OK(ev[3]), .UP_FAIL(ev[4]), .CONN_OK(ev[5]), .CONN_FAIL(ev[6]),
    .REG_OK(ev[7]), .REG_FAIL(ev[8]), .MULTI_TX(mtx), .TX_SET(txs),
    .SINGLE_UPSTREAM_CHANNEL_ID(8'h00), .NO_FWD(ev[9]), .NETWORK_ACCESS_CONTROL_VAL(network_access_control),
    .MAX_CPE_VAL(mcpe), .CC_DEPART(ev[10]), .CC_INIT_TYPE(cct),
    .MAC_REINIT(ev[11]), .RETUNE(pv[0]), .TUNE_CHAN(tch),
    .FWD_DCD(pv[1]), .MDD_COLLECT(pv[2]), .LEGACY_INIT(pv[3]),
    .UP_TX_EN(up_en), .SCAN_DONE(pv[4]), .TWOWAY_OK(pv[5]), .UPSTREAM_CHANNEL_ID(upstream_channel_id),
    .ONEWAY(pv[6]), .CANT_FWD(pv[7]), .NETWORK_ACCESS_CONTROL_OUT(nout),
    .MAX_CPE_OUT(mout), .CC_DEPART_OUT(pv[8]), .CC_TYPE_OUT(ctyp),
    .DCD_INFO(pv[9]), .REINIT_OUT(pv[10]), .FILTER_MAC_OUT(fout),
    .TX_DISABLED(txdis)
  );
  gmi_ctrl_model ctrl (
    .clk(clk), .resetn(resetn), .go(ev[15]), .fwd(pv[1]), .accept(acc),
    .dly(dly), .start_adv(sadv), .valid_cmd(vld), .hunt_cmd(hnt)
  );
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t ns: got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] low(input logic [7:0] v);
    low = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        low = 8'(i);
      end
    end
  endfunction
  // one-cycle event, returns once its registered answer is visible
  task automatic pul(input int i);
    @(posedge clk);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev[i] <= 1'b0;
    #1;
  endtask
  task automatic waitp(input int i, input int n);
    int k;
    k = 0;
    while (pv[i] !== 1'b1 && k < n) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk(pv[i], 1'b1);
    if (pv[i] !== 1'b1) begin
      print_verdict();
    end
  endtask
  task automatic quiet(input int n, input logic [10:0] m);
    repeat (n) begin
      chk(pv & m, 11'h000);
      @(posedge clk);
      #1;
    end
  endtask
  task automatic start();
    resetn <= 1'b0;
    lk <= 1'b1;
    tok <= 1'b1;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    #1;
    chk(upstream_channel_id, 8'hff);
    pul(0);
    quiet(10, 11'h7ff);
    pul(15);
    waitp(0, 8);
  endtask
  task automatic dcd();
    repeat (2) @(posedge clk);
    dsrc <= 48'({$urandom(), $urandom()});
    pul(0);
    waitp(4, 3);
    chk(pv[9], 1'b1);
  endtask
  task automatic mdd_sg();
    msrc <= ~dsrc;
    pul(1);
    quiet(3, 11'h00c);
    msrc <= dsrc;
    pul(1);
    waitp(2, 3);
    sgc <= 8'($urandom_range(255, 1));
    pul(2);
    waitp(1, 3);
  endtask
  initial begin
    void'($urandom(25214));
    start();
    c = int'(tch);
    @(posedge clk);
    #1;
    lk <= 1'b0;
    waitp(0, 30);
    chk(tch, 8'(c + 1));
    fch <= 8'($urandom);
    pul(16);
    chk(tch, fch);
    tok <= 1'b0;
    lk <= 1'b1;
    waitp(0, 3);
    chk(tch, 8'(fch + 1));
    tok <= 1'b1;
    dcd();
    mdd_sg();
    waitp(0, 6);
    chk(tch, low(sgc));
    dsrc <= ~msrc;
    pul(0);
    quiet(4, 11'h002);
    dsrc <= msrc;
    acc <= 1'b1;
    dly <= 4'h5;
    pul(0);
    waitp(1, 4);
    repeat (9) @(posedge clk);
    pul(4);
    waitp(6, 3);
    quiet(5, 11'h001);
    start();
    dly <= 4'h0;
    mtx <= 1'b1;
    txs <= 8'($urandom_range(255, 1));
    dcd();
    mdd_sg();
    repeat (3) @(posedge clk);
    pul(3);
    pul(5);
    pul(7);
    waitp(5, 3);
    chk(upstream_channel_id, low(txs));
    chk(up_en, 1'b1);
    cch <= 8'($urandom);
    pul(17);
    waitp(0, 3);
    chk(tch, cch);
    network_access_control <= 8'($urandom);
    mcpe <= 8'($urandom);
    cct <= 2'($urandom);
    pul(9);
    waitp(7, 3);
    chk({nout, mout}, {network_access_control, mcpe});
    pul(10);
    waitp(8, 3);
    chk(ctyp, cct);
    fmac <= 48'({$urandom(), $urandom()});
    pul(12);
    chk(fout, fmac);
    pul(11);
    waitp(10, 3);
    pul(13);
    chk(up_en, 1'b0);
    chk(txdis[0], 1'b1);
    pul(14);
    start();
    dcd();
    pul(0);
    waitp(3, 3);
    print_verdict();
  end
endmodule // tb_gateway_modem_init_fsm
